// file: rsf_defs.vh
`ifndef RSF_DEFS_VH
`define RSF_DEFS_VH
`define RSF_CRC_INIT     16'hffff
`define RSF_CRC_POLY     16'ha001
`define RSF_OP_READ      8'h03
`define RSF_OP_WRITE     8'h06
`define RSF_ADDR_BCAST   8'h00
`define RSF_ADDR_MAX     8'hf7
`define RSF_EXC_FLAG     8'h80
`define RSF_ERR_OPCODE   8'h01
`define RSF_ERR_ADDR     8'h02
`define RSF_ERR_DATA     8'h03
`define RSF_ERR_BUSY     8'h04
`define RSF_MAX_WORDS    16'h000c
`define RSF_RX_BYTES     4'h8
`define RSF_IDLE_TENTHS  35
`define RSF_CNT_W        24
`define RSF_FIFO_DEPTH   16
`define RSF_FIFO_AW      4
`endif

// file: rsf_fifo.v
`timescale 1ns/10ps
module rsf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_r;
  reg [AW-1:0]    rdPtr_r;
  reg [AW:0]      count_r;
  wire            doWr;
  wire            doRd;

  assign inReady  = (count_r != DEPTH[AW:0]);
  assign outValid = (count_r != {(AW+1){1'b0}});
  assign doWr     = inValid & inReady;
  assign doRd     = outValid & outReady;

  always @* begin
    outData = mem[rdPtr_r];
  end

  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      if (doWr & ~doRd) begin
        count_r <= count_r + 1'b1;
      end else if (doRd & ~doWr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // rsf_fifo

// file: rsf_frame_handler.v
// Notes on behaviour
// - Act only on own station address or broadcast zero; addresses 0..247.
// - Line idle over 3.5 character times starts a new frame.
// - Half duplex: receive always, drive only while sending a reply; only ST_RX takes bytes and the drive runs on through the closing gap.
// - Individually addressed requests that arrive intact always get a reply.
// - Broadcast requests are executed but never answered.
// - Only word read 0x03 and word write 0x06 are supported.
// - Request: address, opcode, word address, count or data, CRC.
// - Write changes one word; data follows the word address.
// - Faulty frames are dropped silently; bad requests or failed accesses get an error reply; here only failed writes do, a failed read word goes out as zero.
// - Error codes 01 opcode, 02 address, 03 data, 04 cannot process.
// - Trailing 16-bit CRC is checked; mismatch is a transmission error.
// - CRC preset to all ones, fed only with the data bits.
// - Per byte: xor in, eight right shifts, xor 0xa001 on carry.
// - CRC low byte goes out before high byte.
// - Frames are surrounded by at least 3.5 character times of silence.
`timescale 1ns/10ps
`include "rsf_defs.vh"
module rsf_frame_handler #(
  parameter [`RSF_CNT_W-1:0] CHAR_CYCLES = 24'd11459
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Station setting
  input  wire [7:0]  stationAddr,
  // Received characters from the UART
  input  wire        rxValid,
  input  wire [7:0]  rxData,
  input  wire        rxError,
  input  wire        lineActive,
  // Transmit characters to the UART
  output wire        txValid,
  input  wire        txReady,
  output wire [7:0]  txData,
  input  wire        txBusy,
  output reg         driverOe_n,
  // Parameter access port
  output reg         accRead,
  output reg         accWrite,
  output reg  [15:0] accAddr,
  output reg  [15:0] accWrData,
  input  wire        accDone,
  input  wire        accFail,
  input  wire [7:0]  accErrCode,
  input  wire [15:0] accRdData,
  // Status pulses
  output reg         frameDropped,
  output reg         frameDone
);
  localparam [31:0] IDLE_FULL = (CHAR_CYCLES * `RSF_IDLE_TENTHS + 9) / 10;
  localparam [`RSF_CNT_W-1:0] IDLE_CYCLES = IDLE_FULL[`RSF_CNT_W-1:0];

  localparam [6:0] ST_RX   = 7'h01;
  localparam [6:0] ST_EXEC = 7'h02;
  localparam [6:0] ST_ACC  = 7'h04;
  localparam [6:0] ST_HDR  = 7'h08;
  localparam [6:0] ST_BODY = 7'h10;
  localparam [6:0] ST_CRC  = 7'h20;
  localparam [6:0] ST_GAP  = 7'h40;

  function [15:0] crcByte;
    input [15:0] crcIn;
    input [7:0]  dataIn;
    integer      i;
    reg   [15:0] c;
    begin
      c = crcIn ^ {8'h00, dataIn};
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0]) begin
          c = (c >> 1) ^ `RSF_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crcByte = c;
    end
  endfunction

  // Pin-side status synchronised
  reg        actS1_r, actS2_r, bsyS1_r, bsyS2_r;
  reg [6:0]  state_r;
  reg [`RSF_CNT_W-1:0] idleCnt_r;
  reg        idleSeen_r;
  reg [7:0]  rxBuf_r [0:7];
  reg [3:0]  rxCnt_r;
  reg        rxBad_r;
  reg [15:0] rxCrc_r;
  reg [15:0] rxCrcPrev_r;
  reg [15:0] rxCrcPrev2_r;
  reg [7:0]  errCode_r;
  reg [15:0] wordsLeft_r;
  reg [4:0]  hdrIdx_r;
  reg [15:0] txCrc_r;
  reg        crcHi_r;
  reg [7:0]  txByte_r;
  reg        txPend_r;
  reg        bcast_r;
  reg        accBusy_r;
  wire [15:0] rxWord2  = {rxBuf_r[2], rxBuf_r[3]};
  wire [15:0] rxWord4  = {rxBuf_r[4], rxBuf_r[5]};
  wire [15:0] rxCrcIn  = {rxBuf_r[7], rxBuf_r[6]};
  wire        idleNow  = (idleCnt_r >= IDLE_CYCLES);
  wire        addrMine = (rxBuf_r[0] == stationAddr) &&
                         (stationAddr != `RSF_ADDR_BCAST) &&
                         (stationAddr <= `RSF_ADDR_MAX);
  wire        addrBc   = (rxBuf_r[0] == `RSF_ADDR_BCAST);

  // Reply bytes queue ahead of the UART so access latency never gaps them
  wire        fifoInReady;
  wire        fifoPush = txPend_r & fifoInReady;

  rsf_fifo #(
    .WIDTH (8),
    .DEPTH (`RSF_FIFO_DEPTH),
    .AW    (`RSF_FIFO_AW)
  ) u_txFifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (txPend_r),
    .inReady  (fifoInReady),
    .inData   (txByte_r),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (txData)
  );

  always @(posedge clk) begin
    if (!reset_n) begin
      actS1_r <= 1'b0;
      actS2_r <= 1'b0;
      bsyS1_r <= 1'b0;
      bsyS2_r <= 1'b0;
    end else begin
      actS1_r <= lineActive;
      actS2_r <= actS1_r;
      bsyS1_r <= txBusy;
      bsyS2_r <= bsyS1_r;
    end
  end

  // Idle timer restarts on any line activity
  always @(posedge clk) begin
    if (!reset_n) begin
      idleCnt_r <= {`RSF_CNT_W{1'b0}};
    end else if (actS2_r || rxValid || bsyS2_r || txValid) begin
      idleCnt_r <= {`RSF_CNT_W{1'b0}};
    end else if (!idleNow) begin
      idleCnt_r <= idleCnt_r + 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_r      <= ST_RX;
      idleSeen_r   <= 1'b0;
      rxCnt_r      <= 4'h0;
      rxBad_r      <= 1'b0;
      rxCrc_r      <= `RSF_CRC_INIT;
      rxCrcPrev_r  <= `RSF_CRC_INIT;
      rxCrcPrev2_r <= `RSF_CRC_INIT;
      errCode_r    <= 8'h00;
      wordsLeft_r  <= 16'h0000;
      hdrIdx_r     <= 5'h00;
      txCrc_r      <= `RSF_CRC_INIT;
      crcHi_r      <= 1'b0;
      txByte_r     <= 8'h00;
      txPend_r     <= 1'b0;
      bcast_r      <= 1'b0;
      accBusy_r    <= 1'b0;
      driverOe_n   <= 1'b1;
      accRead      <= 1'b0;
      accWrite     <= 1'b0;
      accAddr      <= 16'h0000;
      accWrData    <= 16'h0000;
      frameDropped <= 1'b0;
      frameDone    <= 1'b0;
    end else begin
      frameDropped <= 1'b0;
      frameDone    <= 1'b0;
      accRead      <= 1'b0;
      accWrite     <= 1'b0;
      if (fifoPush) begin
        txPend_r <= 1'b0;
        txCrc_r  <= crcHi_r ? txCrc_r : crcByte(txCrc_r, txByte_r);
      end
      case (state_r)
        ST_RX: begin
          driverOe_n <= 1'b1;
          if (rxValid) begin
            if (idleSeen_r) begin
              idleSeen_r <= 1'b0;
              rxBuf_r[0] <= rxData;
              rxCnt_r    <= 4'h1;
              rxBad_r    <= rxError;
              rxCrc_r    <= crcByte(`RSF_CRC_INIT, rxData);
              rxCrcPrev_r  <= `RSF_CRC_INIT;
              rxCrcPrev2_r <= `RSF_CRC_INIT;
            end else if (rxCnt_r != 4'h0) begin
              if (rxCnt_r < `RSF_RX_BYTES) begin
                rxBuf_r[rxCnt_r[2:0]] <= rxData;
                rxCnt_r <= rxCnt_r + 1'b1;
              end
              rxBad_r      <= rxBad_r | rxError | (rxCnt_r >= `RSF_RX_BYTES);
              rxCrcPrev2_r <= rxCrcPrev_r;
              rxCrcPrev_r  <= rxCrc_r;
              rxCrc_r      <= crcByte(rxCrc_r, rxData);
            end
          end else if (idleNow && !idleSeen_r) begin
            idleSeen_r <= 1'b1;
            if (rxCnt_r != 4'h0) begin
              rxCnt_r <= 4'h0;
              state_r <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          bcast_r   <= addrBc;
          errCode_r <= 8'h00;
          hdrIdx_r  <= 5'h00;
          txCrc_r   <= `RSF_CRC_INIT;
          crcHi_r   <= 1'b0;
          accAddr   <= rxWord2;
          accWrData <= rxWord4;
          wordsLeft_r <= rxWord4;
          if (!(addrMine || addrBc) || rxBad_r ||
              rxCrcPrev2_r != rxCrcIn) begin
            frameDropped <= 1'b1;
            state_r      <= ST_RX;
          end else if (rxBuf_r[1] != `RSF_OP_READ &&
                       rxBuf_r[1] != `RSF_OP_WRITE) begin
            errCode_r <= `RSF_ERR_OPCODE;
            state_r   <= ST_HDR;
          end else if (rxBuf_r[1] == `RSF_OP_READ &&
                       (rxWord4 == 16'h0000 ||
                        rxWord4 > `RSF_MAX_WORDS)) begin
            errCode_r <= `RSF_ERR_DATA;
            state_r   <= ST_HDR;
          end else if (rxBuf_r[1] == `RSF_OP_WRITE) begin
            accWrite <= 1'b1;
            state_r  <= ST_ACC;
          end else begin
            state_r <= ST_HDR;
          end
        end
        ST_ACC: begin
          if (accDone) begin
            if (accFail) begin
              errCode_r <= (accErrCode == 8'h00) ?
                           `RSF_ERR_BUSY : accErrCode;
            end
            state_r <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (bcast_r) begin
            frameDone <= 1'b1;
            state_r   <= ST_RX;
          end else if (!txPend_r || fifoPush) begin
            driverOe_n <= 1'b0;
            txPend_r   <= 1'b1;
            hdrIdx_r   <= hdrIdx_r + 1'b1;
            if (errCode_r != 8'h00) begin
              case (hdrIdx_r)
                5'h00:   txByte_r <= rxBuf_r[0];
                5'h01:   txByte_r <= rxBuf_r[1] | `RSF_EXC_FLAG;
                default: txByte_r <= errCode_r;
              endcase
              if (hdrIdx_r == 5'h02) begin
                state_r <= ST_CRC;
              end
            end else if (rxBuf_r[1] == `RSF_OP_WRITE) begin
              txByte_r <= rxBuf_r[hdrIdx_r[2:0]];
              if (hdrIdx_r == 5'h05) begin
                state_r <= ST_CRC;
              end
            end else begin
              case (hdrIdx_r)
                5'h00:   txByte_r <= rxBuf_r[0];
                5'h01:   txByte_r <= rxBuf_r[1];
                default: txByte_r <= {wordsLeft_r[6:0], 1'b0};
              endcase
              if (hdrIdx_r == 5'h02) begin
                state_r <= ST_BODY;
              end
            end
          end
        end
        ST_BODY: begin
          if (accDone) begin
            // A failed word mid-reply cannot be recalled; it reads as zero
            accBusy_r <= 1'b0;
            txPend_r  <= 1'b1;
            hdrIdx_r  <= hdrIdx_r + 1'b1;
            if (hdrIdx_r[0]) begin
              txByte_r <= accFail ? 8'h00 : accRdData[15:8];
            end else begin
              txByte_r    <= accFail ? 8'h00 : accRdData[7:0];
              accAddr     <= accAddr + 16'h0001;
              wordsLeft_r <= wordsLeft_r - 16'h0001;
              if (wordsLeft_r == 16'h0001) begin
                state_r <= ST_CRC;
              end
            end
          end else if (!txPend_r && !accBusy_r) begin
            accBusy_r <= 1'b1;
            accRead   <= 1'b1;
          end
        end
        ST_CRC: begin
          if (!txPend_r) begin
            txPend_r <= 1'b1;
            if (!crcHi_r) begin
              txByte_r <= txCrc_r[7:0];
              crcHi_r  <= 1'b1;
            end else begin
              txByte_r <= txCrc_r[15:8];
              state_r  <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          if (!txPend_r && !txValid && !bsyS2_r && idleNow) begin
            driverOe_n <= 1'b1;
            frameDone  <= 1'b1;
            idleSeen_r <= 1'b1;
            state_r    <= ST_RX;
          end
        end
        default: state_r <= ST_RX;
      endcase
    end
  end
endmodule // rsf_frame_handler

// file: rsf_master_model.sv
`timescale 1ns/10ps
module rsf_master_model #(
  parameter int CHAR = 20
) (
  // Clock
  input  wire logic       clk,
  // Characters towards the handler
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            lineActive,
  // Characters from the handler
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  output logic            txBusy
);
  logic [7:0] got[$];
  int         busyCnt;

  initial begin
    rxValid    = 1'b0;
    rxData     = 8'h00;
    lineActive = 1'b0;
    txReady    = 1'b1;
    txBusy     = 1'b0;
    busyCnt    = 0;
  end

  // Shifts one byte per character time, so the reply is paced like a UART
  always @(posedge clk) begin
    if (txValid && txReady) begin
      got.push_back(txData);
      txReady <= 1'b0;
      txBusy  <= 1'b1;
      busyCnt <= CHAR;
    end else if (busyCnt > 0) begin
      busyCnt <= busyCnt - 1;
    end else begin
      txReady <= 1'b1;
      txBusy  <= 1'b0;
    end
  end

  // Sends only when the bench commands a request
  task automatic sendFrame(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge clk);
      lineActive <= 1'b1;
      repeat (CHAR - 1) @(posedge clk);
      rxValid <= 1'b1;
      rxData  <= f[i];
      @(posedge clk);
      rxValid    <= 1'b0;
      lineActive <= 1'b0;
      rxData     <= ~f[i];
    end
  endtask
endmodule // rsf_master_model

// file: rsf_frame_handler_checker.sv
`timescale 1ns/10ps
module rsf_checker (
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Watched ports
  input wire       txValid,
  input wire       txReady,
  input wire [7:0] txData,
  input wire       txBusy,
  input wire       driverOe_n,
  input wire       accRead,
  input wire       accWrite,
  input wire       frameDone,
  input wire       frameDropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_tx_driven:
    assert property (txValid && txReady |=> !driverOe_n)
      else $error("Byte taken while line released");
  a_no_wr_reply:
    assert property (!driverOe_n |-> !accWrite)
      else $error("Write issued while replying");
  a_hold_byte:
    assert property (txValid && !txReady |=> txValid && $stable(txData))
      else $error("Pending byte changed");
  a_acc_pulse:
    assert property ((accRead || accWrite) |=> !(accRead || accWrite))
      else $error("Access strobe longer than a cycle");
  a_status_excl:
    assert property (!(frameDone && frameDropped))
      else $error("Frame both done and dropped");
  a_drop_quiet:
    assert property (frameDropped |-> driverOe_n [*8])
      else $error("Dropped frame drove the line");
  a_oe_release:
    assert property ($rose(driverOe_n) |-> !txValid && !txBusy)
      else $error("Line released with reply pending");
  a_oe_hold:
    assert property ($fell(driverOe_n) |=> !driverOe_n [*8])
      else $error("Line drive too short");
endmodule // rsf_checker

bind rsf_frame_handler rsf_checker chk (
  .clk(clk), .reset_n(reset_n), .txValid(txValid), .txReady(txReady),
  .txData(txData), .txBusy(txBusy), .driverOe_n(driverOe_n),
  .accRead(accRead), .accWrite(accWrite), .frameDone(frameDone),
  .frameDropped(frameDropped));

// file: rsf_frame_handler_bench.sv
`timescale 1ns/10ps
module rsf_frame_handler_bench;
  logic clk, reset_n, rxValid, rxError, lineActive, txValid, txReady, txBusy;
  logic driverOe_n, accRead, accWrite, accDone, accFail;
  logic frameDropped, frameDone, failMode;
  logic [7:0]  stationAddr, rxData, txData, accErrCode, failCode;
  logic [15:0] accAddr, accWrData, accRdData, wrAddr, wrData;
  logic [1:0]  pend;
  logic [7:0]  f[$], e[$];
  int bad_count, checked, evCnt, wrCnt, dropCnt;

  rsf_frame_handler #(.CHAR_CYCLES(24'd20)) dut (.clk(clk),
    .reset_n(reset_n), .stationAddr(stationAddr), .rxValid(rxValid),
    .rxData(rxData), .rxError(rxError), .lineActive(lineActive),
    .txValid(txValid), .txReady(txReady), .txData(txData),
    .txBusy(txBusy), .driverOe_n(driverOe_n), .accRead(accRead),
    .accWrite(accWrite), .accAddr(accAddr), .accWrData(accWrData),
    .accDone(accDone), .accFail(accFail), .accErrCode(accErrCode),
    .accRdData(accRdData), .frameDropped(frameDropped),
    .frameDone(frameDone));
  rsf_master_model #(.CHAR(20)) m (.clk(clk), .rxValid(rxValid),
    .rxData(rxData), .lineActive(lineActive), .txValid(txValid),
    .txData(txData), .txReady(txReady), .txBusy(txBusy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Parameter store answers three cycles after each strobe
  always @(posedge clk) begin
    pend       <= {pend[0], accRead | accWrite};
    accDone    <= pend[1];
    accFail    <= failMode;
    accErrCode <= failCode;
    if (accRead) accRdData <= accAddr ^ 16'ha5c3;
    if (accWrite) begin
      wrCnt  <= wrCnt + 1;
      wrAddr <= accWrData == 16'h0 ? 16'h0 : accAddr;
      wrData <= accWrData;
    end
    if (frameDone === 1'b1 || frameDropped === 1'b1) evCnt <= evCnt + 1;
    if (frameDropped === 1'b1) dropCnt <= dropCnt + 1;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic void addCrc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction

  task automatic xfer(input int wrExp);
    int ev, i, w;
    ev = evCnt;
    w  = wrCnt;
    m.got.delete();
    m.sendFrame(f);
    i = 0;
    while (i < 4000 && !(evCnt != ev && m.got.size() == e.size()
           && driverOe_n === 1'b1)) begin
      @(posedge clk);
      i++;
    end
    check("settled", 16'(i < 4000), 16'd1);
    repeat (100) @(posedge clk);
    check("replyLen", 16'(m.got.size()), 16'(e.size()));
    foreach (e[k])
      if (k < m.got.size()) check("replyByte", m.got[k], e[k]);
    check("writes", 16'(wrCnt - w), 16'(wrExp));
  endtask

  task automatic errFrame(logic [7:0] op, logic [7:0] code);
    e = '{8'h11, op | 8'h80, code};
    addCrc(e);
  endtask

  task automatic tWrite;
    f = '{8'h11, 8'h06, 8'h20, 8'h00, 8'h00, 8'h07};
    addCrc(f);
    e = f;
    xfer(1);
    check("wrAddr", wrAddr, 16'h2000);
    check("wrData", wrData, 16'h0007);
  endtask

  task automatic tRead;
    logic [15:0] d;
    f = '{8'h11, 8'h03, 8'h10, 8'h0a, 8'h00, 8'h0c};
    addCrc(f);
    e = '{8'h11, 8'h03, 8'h18};
    for (int k = 0; k < 12; k++) begin
      d = (16'h100a + 16'(k)) ^ 16'ha5c3;
      e.push_back(d[15:8]);
      e.push_back(d[7:0]);
    end
    addCrc(e);
    xfer(0);
  endtask

  task automatic tBroadcast;
    f = '{8'h00, 8'h06, 8'h20, 8'h01, 8'h00, 8'h05};
    addCrc(f);
    e = {};
    xfer(1);
    check("bcAddr", wrAddr, 16'h2001);
  endtask

  task automatic tForeign;
    int d;
    d = dropCnt;
    f = '{8'h12, 8'h06, 8'h20, 8'h00, 8'h00, 8'h01};
    addCrc(f);
    e = {};
    xfer(0);
    check("drops", 16'(dropCnt - d), 16'd1);
  endtask

  task automatic tBadCrc;
    int d;
    d = dropCnt;
    f = '{8'h11, 8'h06, 8'h20, 8'h00, 8'h00, 8'h02};
    addCrc(f);
    f[7] = ~f[7];
    e = {};
    xfer(0);
    f[7] = ~f[7];
    rxError <= 1'b1;
    xfer(0);
    rxError <= 1'b0;
    f.push_back(8'h00);
    xfer(0);
    check("drops", 16'(dropCnt - d), 16'd3);
  endtask

  task automatic tErrors;
    f = '{8'h11, 8'h10, 8'h20, 8'h00, 8'h00, 8'h01};
    addCrc(f);
    errFrame(8'h10, 8'h01);
    xfer(0);
    f = '{8'h11, 8'h03, 8'h10, 8'h00, 8'h00, 8'h0d};
    addCrc(f);
    errFrame(8'h03, 8'h03);
    xfer(0);
  endtask

  task automatic tFail;
    failMode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      failCode <= k ? 8'h02 : 8'h00;
      f = '{8'h11, 8'h06, 8'h20, 8'h03, 8'h00, 8'h09};
      addCrc(f);
      errFrame(8'h06, k ? 8'h02 : 8'h04);
      xfer(1);
    end
    failMode <= 1'b0;
  endtask

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    rxError = 1'b0;
    stationAddr = 8'h11;
    accDone = 1'b0;
    accFail = 1'b0;
    accErrCode = 8'h00;
    accRdData = 16'h0000;
    pend = 2'b00;
    failMode = 1'b0;
    failCode = 8'h00;
    wrAddr = 16'h0000;
    wrData = 16'h0000;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (100) @(posedge clk);
    tWrite();
    tRead();
    tBroadcast();
    tForeign();
    tBadCrc();
    tErrors();
    tFail();
    summarize();
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule // rsf_frame_handler_bench
